/* logic/counter_array_watchdog_pwm16.sv */
/*
  Counter array core: shared 16-bit counter, six compare channels, control/flag register,
  array mode register and the watchdog function on the last channel.
  Assumes a byte-wide SFR port synchronous to sys_clk, and a system reset block that
  takes a one-cycle reset request.
*/
`timescale 1ns/1ps
module counter_array_watchdog_pwm16
  import cawd_pkg::*;
#(
  parameter int CHANNELS = cawd_pkg::NUM_CHAN
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // system
  input wire logic cpu_idle,
  input wire logic ext_tick,
  output logic array_irq,
  output logic wd_reset_req,
  // waveforms
  output logic [CHANNELS-1:0] pwm_out
);
  import cawd_pkg::*;

  logic wr_ctrl;
  logic wr_amode;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic ovf_flag_q;
  logic run_q;
  logic [CHANNELS-1:0] flag_q;
  logic idle_q;
  logic wde_q;
  logic lock_q;
  logic [2:0] clk_sel_q;
  logic ovf_ie_q;
  logic wd_on;
  logic [3:0] div_q;
  logic sel_tick;
  logic tick;
  logic [15:0] cnt_q;
  logic ovf16;
  logic lo_ovf;
  logic wd_fire;
  logic wd_reset_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_mux;
  logic [15:0] cmp_arr [CHANNELS];
  logic [7:0] mode_arr [CHANNELS];
  logic [CHANNELS-1:0] match_vec;
  logic [CHANNELS-1:0] irq_en_vec;
  logic [7:0] refresh_val;

  chan_if ch [CHANNELS] ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CTRL);
  assign wr_amode = sfr_wr && (sfr_addr == ADDR_AMODE);
  assign wr_cnt_lo = sfr_wr && (sfr_addr == ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr && (sfr_addr == ADDR_CNT_HI);

  // ----------------------------------------------------------------
  // array mode register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_q <= 1'b0;
    end else if (wr_amode && sfr_wdata[AMODE_LCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wde_q <= AMODE_WDE_RESET;
      ovf_ie_q <= 1'b0;
    end else if (wr_amode) begin
      wde_q <= sfr_wdata[AMODE_WDE_BIT];
      ovf_ie_q <= sfr_wdata[AMODE_CFIE_BIT];
    end
  end

  // lock keeps the watchdog alive even though the enable bit itself may read back zero
  assign wd_on = wde_q || lock_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sel_q <= SEL_RESET;
      idle_q <= 1'b0;
    end else if (wr_amode && !wd_on) begin
      clk_sel_q <= sfr_wdata[AMODE_SEL_LSB +: 3];
      idle_q <= sfr_wdata[AMODE_IDLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // array clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 4'h0;
    end else if (div_q == DIV12_LAST) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // codes above the external input stop the counter rather than pick a random source
  always_comb begin
    sel_tick = 1'b0;
    case (clk_sel_q)
      SEL_DIV12: sel_tick = (div_q == DIV12_LAST);
      SEL_DIV4: sel_tick = (div_q[1:0] == DIV4_LAST);
      SEL_SYSCLK: sel_tick = 1'b1;
      SEL_EXT: sel_tick = ext_tick;
      default: sel_tick = 1'b0;
    endcase
  end

  assign tick = sel_tick && (wd_on || run_q) && !(idle_q && cpu_idle);

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  assign ovf16 = tick && (cnt_q == 16'hffff);
  assign lo_ovf = tick && (cnt_q[7:0] == 8'hff);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= CNT_RESET;
    end else if (wr_cnt_lo && !wd_on) begin
      cnt_q[7:0] <= sfr_wdata;
    end else if (wr_cnt_hi && !wd_on) begin
      cnt_q[15:8] <= sfr_wdata;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // control and flag register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovf_flag_q <= CTRL_RESET[CTRL_OVF_BIT];
    end else if (ovf16) begin
      ovf_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      ovf_flag_q <= sfr_wdata[CTRL_OVF_BIT];
    end
  end

  // the stored run bit follows software even while the watchdog holds the counter on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= CTRL_RESET[CTRL_RUN_BIT];
    end else if (wr_ctrl) begin
      run_q <= sfr_wdata[CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // watchdog refresh value and reset request
  // ----------------------------------------------------------------
  assign refresh_val = cnt_q[15:8] + cmp_arr[WD_CHAN][7:0];

  assign wd_fire = wd_on && ((lo_ovf && (cmp_arr[WD_CHAN][15:8] == cnt_q[15:8]))
                   || (wr_ctrl && sfr_wdata[WD_CHAN]));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wd_reset_q <= 1'b0;
    end else begin
      wd_reset_q <= wd_fire;
    end
  end

  assign wd_reset_req = wd_reset_q;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      localparam logic [7:0] IDX = 8'(gi);
      assign ch[gi].count = cnt_q;
      assign ch[gi].tick = tick;
      assign ch[gi].ovf16 = ovf16;
      assign ch[gi].wr_lo = sfr_wr && (sfr_addr == ADDR_CMPLO_BASE + IDX);
      assign ch[gi].wr_hi = sfr_wr && (sfr_addr == ADDR_CMPHI_BASE + IDX);
      assign ch[gi].wr_mode = sfr_wr && (sfr_addr == ADDR_CHMODE_BASE + IDX);
      assign ch[gi].wdata = sfr_wdata;
      assign ch[gi].wd_mode = (gi == WD_CHAN) && wd_on;
      assign ch[gi].hi_wdata = ((gi == WD_CHAN) && wd_on) ? refresh_val : sfr_wdata;
      assign cmp_arr[gi] = ch[gi].cmp;
      assign mode_arr[gi] = ch[gi].mode;
      assign match_vec[gi] = ch[gi].match_evt;
      assign irq_en_vec[gi] = ch[gi].mode[CM_IRQ_BIT];
      assign pwm_out[gi] = ch[gi].pwm;

      // hardware set wins over a firmware clear in the same cycle
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          flag_q[gi] <= CTRL_RESET[gi];
        end else if (match_vec[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (wr_ctrl) begin
          flag_q[gi] <= sfr_wdata[gi];
        end
      end

      compare_channel u_chan (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ch(ch[gi])
      );

      AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        match_vec[gi] |=> flag_q[gi])
        else $error("channel match did not set its flag");
    end
  endgenerate

  // ----------------------------------------------------------------
  // array interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ovf_flag_q && ovf_ie_q) || |(flag_q & irq_en_vec);
    end
  end

  assign array_irq = irq_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (sfr_addr == ADDR_CTRL) begin
      rd_mux = {ovf_flag_q, run_q, 6'(flag_q)};
    end else if (sfr_addr == ADDR_AMODE) begin
      rd_mux = {idle_q, wde_q, lock_q, 1'b0, clk_sel_q, ovf_ie_q};
    end else if (sfr_addr == ADDR_CNT_LO) begin
      rd_mux = cnt_q[7:0];
    end else if (sfr_addr == ADDR_CNT_HI) begin
      rd_mux = cnt_q[15:8];
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (sfr_addr == ADDR_CHMODE_BASE + 8'(i)) begin
        rd_mux = mode_arr[i];
      end else if (sfr_addr == ADDR_CMPLO_BASE + 8'(i)) begin
        rd_mux = cmp_arr[i][7:0];
      end else if (sfr_addr == ADDR_CMPHI_BASE + 8'(i)) begin
        rd_mux = cmp_arr[i][15:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LOCK_HOLDS: assert property (@(posedge sys_clk) disable iff (!resetn)
    lock_q |=> lock_q && wd_on)
    else $error("watchdog dropped while locked");
  AST_UNLOCK_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_amode && !lock_q && !sfr_wdata[AMODE_WDE_BIT] && !sfr_wdata[AMODE_LCK_BIT] |=> !wd_on)
    else $error("clearing enable without lock did not stop watchdog");
  AST_CNT_FROZEN: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on && (wr_cnt_lo || wr_cnt_hi) && !tick |=> $stable(cnt_q))
    else $error("counter write took effect under watchdog");
  AST_FORCED_RUN: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on && sel_tick && !(idle_q && cpu_idle) |-> tick)
    else $error("watchdog did not force the counter on");
  AST_SEL_FROZEN: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on |=> $stable(clk_sel_q) && $stable(idle_q))
    else $error("clock select or idle suspend changed under watchdog");
  AST_IDLE_PAUSE: assert property (@(posedge sys_clk) disable iff (!resetn)
    idle_q && cpu_idle |-> !tick)
    else $error("counter ticked during suspended idle");
  AST_RUN_STOP: assert property (@(posedge sys_clk) disable iff (!resetn)
    !wd_on && !run_q |=> $stable(cnt_q) || $past(wr_cnt_lo) || $past(wr_cnt_hi))
    else $error("stopped counter moved");
  AST_REFRESH: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on && ch[WD_CHAN].wr_hi |=>
      cmp_arr[WD_CHAN][15:8] == 8'($past(cnt_q[15:8]) + $past(cmp_arr[WD_CHAN][7:0])))
    else $error("refresh did not load counter high plus offset");
  AST_WD_FIRE: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on && lo_ovf && (cmp_arr[WD_CHAN][15:8] == cnt_q[15:8]) |=> wd_reset_req)
    else $error("watchdog expiry gave no reset request");
  AST_WD_FORCE: assert property (@(posedge sys_clk) disable iff (!resetn)
    wd_on && wr_ctrl && sfr_wdata[WD_CHAN] |=> wd_reset_req)
    else $error("forced watchdog reset missing");
  AST_OVF_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    ovf16 |=> ovf_flag_q ##1 (ovf_flag_q || $past(wr_ctrl)))
    else $error("overflow flag not set on wrap");

endmodule

/* common/cawd_pkg.sv */
/*
  Constants for the counter array with its 16-bit PWM channels and watchdog function:
  register addresses, field positions, reset values and timing counts.
  Assumes a byte-wide special-function register port on the embedded CPU side.
*/
package cawd_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 6;
  localparam int WD_CHAN = 5;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'hd8;
  localparam logic [7:0] ADDR_AMODE = 8'hd9;
  localparam logic [7:0] ADDR_CHMODE_BASE = 8'hda;
  localparam logic [7:0] ADDR_CMPLO_BASE = 8'he0;
  localparam logic [7:0] ADDR_CMPHI_BASE = 8'hf0;
  localparam logic [7:0] ADDR_CNT_LO = 8'hf9;
  localparam logic [7:0] ADDR_CNT_HI = 8'hfa;

  // ----------------------------------------------------------------
  // counter_control_flags fields
  // ----------------------------------------------------------------
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // array_mode_reg fields
  // ----------------------------------------------------------------
  localparam int AMODE_IDLE_BIT = 7;
  localparam int AMODE_WDE_BIT = 6;
  localparam int AMODE_LCK_BIT = 5;
  localparam int AMODE_SEL_LSB = 1;
  localparam int AMODE_CFIE_BIT = 0;
  localparam logic AMODE_WDE_RESET = 1'b1;

  // array_clock_select codes
  localparam logic [2:0] SEL_DIV12 = 3'b000;
  localparam logic [2:0] SEL_DIV4 = 3'b001;
  localparam logic [2:0] SEL_SYSCLK = 3'b010;
  localparam logic [2:0] SEL_EXT = 3'b011;
  localparam logic [2:0] SEL_RESET = SEL_DIV12;

  // ----------------------------------------------------------------
  // per-channel mode register fields
  // ----------------------------------------------------------------
  localparam int CM_IRQ_BIT = 0;
  localparam int CM_PWM_BIT = 1;
  localparam int CM_MATCH_BIT = 3;
  localparam int CM_CMPEN_BIT = 6;
  localparam int CM_WIDE_BIT = 7;
  localparam logic [7:0] CHMODE_RESET = 8'h00;
  localparam logic [7:0] SW_TIMER_MODE = 8'h48;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [3:0] DIV12_LAST = 4'd11;
  localparam logic [1:0] DIV4_LAST = 2'd3;
  localparam int SYSCLK_PER_DIV12 = 12;
  localparam int WD_TIMEOUT_TICKS = 256;
  localparam int WD_TIMEOUT_SYSCLK = WD_TIMEOUT_TICKS * SYSCLK_PER_DIV12;

endpackage

/* common/chan_if.sv */
/*
  Bundle between the array core and one compare channel.
  Assumes the core drives counter state and decoded writes; the channel returns its state.
*/
`timescale 1ns/1ps
interface chan_if;
  logic [15:0] count;
  logic tick;
  logic ovf16;
  logic wr_lo;
  logic wr_hi;
  logic wr_mode;
  logic [7:0] wdata;
  logic [7:0] hi_wdata;
  logic wd_mode;
  logic [15:0] cmp;
  logic [7:0] mode;
  logic match_evt;
  logic pwm;

  modport ctl(output count, tick, ovf16, wr_lo, wr_hi, wr_mode, wdata, hi_wdata, wd_mode,
              input cmp, mode, match_evt, pwm);
  modport chan(input count, tick, ovf16, wr_lo, wr_hi, wr_mode, wdata, hi_wdata, wd_mode,
               output cmp, mode, match_evt, pwm);
endinterface

/* logic/compare_channel.sv */
/*
  One compare channel: compare register, mode register, match detect, 16-bit PWM.
  Assumes the core gives one-cycle tick and overflow pulses and mutually exclusive writes.
*/
`timescale 1ns/1ps
module compare_channel
  import cawd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // core side
  chan_if.chan ch
);
  import cawd_pkg::*;

  logic [7:0] mode_q;
  logic [15:0] cmp_q;
  logic pwm_q;
  logic [7:0] eff_mode;
  logic pwm16;
  logic hit;

  // ----------------------------------------------------------------
  // mode and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= CHMODE_RESET;
    end else if (ch.wr_mode && !ch.wd_mode) begin
      mode_q <= ch.wdata;
    end else if (ch.wr_hi) begin
      mode_q[CM_CMPEN_BIT] <= 1'b1;
    end else if (ch.wr_lo) begin
      mode_q[CM_CMPEN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_q <= CMP_RESET;
    end else if (ch.wr_hi) begin
      cmp_q[15:8] <= ch.hi_wdata;
    end else if (ch.wr_lo) begin
      cmp_q[7:0] <= ch.wdata;
    end
  end

  // watchdog duty overrides whatever software left in the mode register
  assign eff_mode = ch.wd_mode ? SW_TIMER_MODE : mode_q;
  assign pwm16 = eff_mode[CM_CMPEN_BIT] && eff_mode[CM_PWM_BIT] && eff_mode[CM_WIDE_BIT];
  assign hit = ch.tick && eff_mode[CM_CMPEN_BIT] && (ch.count == cmp_q);

  // ----------------------------------------------------------------
  // match event and waveform
  // ----------------------------------------------------------------
  // in watchdog duty the last channel's flag is a software reset trigger, so no match sets it
  assign ch.match_evt = hit && eff_mode[CM_MATCH_BIT] && !ch.wd_mode;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_q <= 1'b0;
    end else if (!pwm16) begin
      pwm_q <= 1'b0;
    end else if (hit) begin
      pwm_q <= 1'b1;
    end else if (ch.ovf16) begin
      pwm_q <= 1'b0;
    end
  end

  assign ch.cmp = cmp_q;
  assign ch.mode = eff_mode;
  assign ch.pwm = pwm_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CMPEN_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
    ch.wr_lo && !ch.wr_hi && !ch.wr_mode |=> !mode_q[CM_CMPEN_BIT])
    else $error("low compare write left compare enable set");
  AST_CMPEN_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    ch.wr_hi && !ch.wr_mode |=> mode_q[CM_CMPEN_BIT])
    else $error("high compare write did not set compare enable");
  AST_PWM_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
    !pwm16 |=> !pwm_q)
    else $error("waveform high outside 16-bit pwm");

endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the counter array core with its watchdog and 16-bit pwm.
  Assumes the core's byte-wide sfr port and the constants of cawd_pkg; drives every port itself.
*/
`timescale 1ns/1ps
module tb;
  import cawd_pkg::*;
  logic sys_clk, resetn, sfr_wr, sfr_rd, cpu_idle, ext_tick, array_irq, wd_reset_req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_v;
  logic [5:0] pwm_out;
  int bad_count = 0, checked = 0, cyc = 0, rel_cyc = 0, pulses = 0, pulse_cyc = 0, p0 = 0;

  counter_array_watchdog_pwm16 counter_array_watchdog_pwm16_inst (.sys_clk(sys_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .cpu_idle(cpu_idle), .ext_tick(ext_tick), .array_irq(array_irq), .wd_reset_req(wd_reset_req),
    .pwm_out(pwm_out));

  // ----------------------------------------------------------------
  // clock, pulse monitor, shared tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // counting high samples shows both the count and the one-cycle width of each request
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (wd_reset_req === 1'b1) begin
      pulses <= pulses + 1;
      pulse_cyc <= cyc;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_in(input int v, input int lo, input int hi, input string msg);
    checked++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, msg, v, lo, hi);
    end
  endtask

  // an idle cycle after each strobe keeps a strobe from being assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    rd_v = sfr_rdata;
    step(1);
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    step(3);
    resetn = 1'b1;
    rel_cyc = cyc;
    p0 = pulses;
  endtask

  task automatic wait_to(input int n);
    while (cyc < rel_cyc + n) step(1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wd_default();
    do_reset();
    rd(ADDR_CTRL);
    chk(rd_v, CTRL_RESET, "control reset");
    rd(ADDR_AMODE);
    chk(rd_v & 8'h4e, 8'h40, "mode reset");
    wr(ADDR_CHMODE_BASE + 8'h05, 8'h00);
    rd(ADDR_CHMODE_BASE + 8'h05);
    chk(rd_v, SW_TIMER_MODE, "last mode forced");
    wr(ADDR_AMODE, 8'hc6);
    rd(ADDR_AMODE);
    chk(rd_v & 8'h8e, 8'h00, "select frozen");
    wr(ADDR_CNT_LO, 8'h80);
    rd(ADDR_CNT_LO);
    chk(rd_v & 8'hf0, 8'h00, "counter write ignored");
    wait_to(3090);
    chk_in(pulses - p0, 1, 1, "timeout pulses");
    chk_in(pulse_cyc - rel_cyc, 3071, 3074, "default timeout");
    $display("test wd_default done");
  endtask

  task automatic t_refresh();
    do_reset();
    wr(ADDR_CMPLO_BASE + 8'h05, 8'h01);
    wr(ADDR_CMPHI_BASE + 8'h05, 8'h5a);
    rd(ADDR_CMPHI_BASE + 8'h05);
    chk(rd_v, 8'h01, "refresh load");
    wait_to(6160);
    chk_in(pulses - p0, 1, 1, "refresh pulses");
    chk_in(pulse_cyc - rel_cyc, 6143, 6146, "offset timeout");
    $display("test refresh done");
  endtask

  task automatic t_force_lock();
    do_reset();
    wr(ADDR_CTRL, 8'h20);
    chk_in(pulses - p0, 1, 1, "forced reset");
    wr(ADDR_AMODE, 8'h20);
    wr(ADDR_AMODE, 8'h00);
    wr(ADDR_CTRL, 8'h20);
    chk_in(pulses - p0, 2, 2, "lock holds watchdog");
    $display("test force_lock done");
  endtask

  // firmware order: disable, clock source, offset, idle choice, enable, refresh
  task automatic t_wd_config();
    do_reset();
    wr(ADDR_AMODE, 8'h00);
    wr(ADDR_CNT_LO, 8'h80);
    wr(ADDR_AMODE, 8'h04);
    wr(ADDR_CMPLO_BASE + 8'h05, 8'h02);
    wr(ADDR_AMODE, 8'h04);
    wr(ADDR_AMODE, 8'h44);
    wr(ADDR_CMPHI_BASE + 8'h05, 8'h00);
    rel_cyc = cyc;
    wait_to(650);
    chk_in(pulses - p0, 1, 1, "configured pulses");
    chk_in(pulse_cyc - rel_cyc, 636, 638, "low byte timeout");
    $display("test wd_config done");
  endtask

  task automatic t_run_idle();
    logic [7:0] base;
    do_reset();
    wr(ADDR_AMODE, 8'h00);
    wr(ADDR_AMODE, 8'h04);
    rd(ADDR_AMODE);
    chk(rd_v, 8'h04, "select after disable");
    wr(ADDR_CTRL, 8'h20);
    chk_in(pulses - p0, 0, 0, "no forced reset when off");
    wr(ADDR_CNT_LO, 8'h10);
    step(4);
    rd(ADDR_CNT_LO);
    chk(rd_v, 8'h10, "stopped counter");
    wr(ADDR_AMODE, 8'h84);
    cpu_idle = 1'b1;
    wr(ADDR_CTRL, 8'h40);
    step(4);
    rd(ADDR_CNT_LO);
    chk(rd_v, 8'h10, "idle suspends");
    cpu_idle = 1'b0;
    step(10);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO);
    chk_in(rd_v, 8'h19, 8'h1c, "counting per tick");
    base = rd_v;
    wr(ADDR_AMODE, 8'h06);
    wr(ADDR_CTRL, 8'h40);
    repeat (3) begin
      ext_tick = 1'b1;
      step(1);
      ext_tick = 1'b0;
      step(1);
    end
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO);
    chk(rd_v, base + 8'h03, "external ticks");
    $display("test run_idle done");
  endtask

  task automatic t_pwm16();
    do_reset();
    wr(ADDR_AMODE, 8'h00);
    wr(ADDR_AMODE, 8'h05);
    wr(ADDR_CMPLO_BASE, 8'h10);
    wr(ADDR_CMPHI_BASE, 8'h80);
    rd(ADDR_CHMODE_BASE);
    chk(rd_v & 8'h40, 8'h40, "high write sets enable");
    wr(ADDR_CMPLO_BASE, 8'h10);
    rd(ADDR_CHMODE_BASE);
    chk(rd_v & 8'h40, 8'h00, "low write clears enable");
    wr(ADDR_CMPHI_BASE, 8'h80);
    wr(ADDR_CHMODE_BASE, 8'hcb);
    wr(ADDR_CNT_HI, 8'h7f);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    step(30);
    chk(pwm_out, 8'h00, "no low-byte match");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_HI, 8'h80);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    step(30);
    chk(pwm_out, 8'h01, "match edge");
    rd(ADDR_CTRL);
    chk(rd_v, 8'h41, "match flag");
    chk(array_irq, 1'b1, "match irq");
    wr(ADDR_CMPLO_BASE, 8'h10);
    wr(ADDR_CMPHI_BASE, 8'h80);
    rd(ADDR_CHMODE_BASE);
    chk(rd_v, 8'hcb, "paced duty update");
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CTRL, 8'h40);
    step(30);
    chk(pwm_out, 8'h00, "overflow edge");
    rd(ADDR_CTRL);
    chk(rd_v, 8'hc0, "overflow flag");
    chk(array_irq, 1'b1, "overflow irq");
    rd(ADDR_CNT_HI);
    chk(rd_v, 8'h00, "high byte wrapped");
    wr(ADDR_CTRL, 8'h00);
    step(2);
    chk(array_irq, 1'b0, "irq cleared");
    $display("test pwm16 done");
  endtask

  // ----------------------------------------------------------------
  // sequence, verdict, watchdog
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    cpu_idle = 1'b0;
    ext_tick = 1'b0;
    t_wd_default();
    t_refresh();
    t_force_lock();
    t_wd_config();
    t_run_idle();
    t_pwm16();
    finish_test();
  end

  initial begin
    #(50 * 30000);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    finish_test();
  end
endmodule
